// [hdl/mvd_defs.vh]
// mvd_defs.vh: instruction encoding, widths and reset values for the move datapath.
// assumes it is included by bare name from design files under hdl/.
`ifndef MVD_DEFS_VH
`define MVD_DEFS_VH

// 14-bit instruction word, top three bits pick the move kind
`define MVD_OP_HI 13
`define MVD_OP_LO 11
`define MVD_OP_NOP 3'h0
`define MVD_OP_REG_DEST 3'h1
`define MVD_OP_IND_LOAD 3'h2
`define MVD_OP_LIT_BANK 3'h3
`define MVD_OP_LIT_PCU 3'h4
`define MVD_OP_LIT_ACC 3'h5
`define MVD_OP_ACC_REG 3'h6

// field positions
`define MVD_DEST_BIT 7
`define MVD_FADDR_HI 6
`define MVD_FADDR_LO 0
`define MVD_PSEL_BIT 8
`define MVD_REL_BIT 7
`define MVD_MODE_HI 1
`define MVD_MODE_LO 0
`define MVD_OFS_HI 5
`define MVD_OFS_LO 0
`define MVD_LIT_HI 7
`define MVD_LIT_LO 0

// pointer update modes
`define MVD_MODE_PREINC 2'h0
`define MVD_MODE_PREDEC 2'h1
`define MVD_MODE_POSTINC 2'h2
`define MVD_MODE_POSTDEC 2'h3

// reset values
`define MVD_RST_ACC 8'h00
`define MVD_RST_BANK 5'h00
`define MVD_RST_PCU 7'h00
`define MVD_RST_PTR 16'h0000

`endif

// [hdl/mvd_file_ram.v]
// mvd_file_ram.v: small synchronous memory standing in for the file registers.
// assumes one write port and one read port on the same clock; read data registered.
`default_nettype none

module mvd_file_ram #(
	parameter AW = 7,
	parameter DW = 8
) (
	input wire mclk_i,
	input wire ce_i,
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [DW-1:0] wdata_i,
	input wire [AW-1:0] raddr_i,
	output reg [DW-1:0] rdata_o
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	// registered read, write has no bypass to the read port
	always @(posedge mclk_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem[waddr_i] <= wdata_i;
			end
			rdata_o <= mem[raddr_i];
		end
	end

endmodule

`default_nettype wire

// [hdl/mvd_move_datapath.v]
// mvd_move_datapath.v: execution of the data-move instructions of an 8-bit core.
// assumes the decoder holds instr_i one cycle while exec_i is high; data memory answers one cycle later.
//
// What this block does
// - register move with dest 0 copies file register into accumulator only.
// - register move with dest 1 writes file register value back to itself.
// - register move updates zero flag from the moved value, either destination.
// - indirect load reads memory at pointer address into accumulator.
// - effective address is pointer, pointer+1, pointer-1, or pointer plus signed offset -32..31.
// - pointer becomes +1 for increments, -1 for decrements, unchanged for offset form.
// - mode 00 preinc, 01 predec, 10 postinc, 11 postdec; one bit picks pointer.
// - pointers are 16-bit and wrap past FFFFh or below 0000h.
// - literal-to-bank loads 5-bit value into bank pointer, flags untouched.
// - literal-to-latch loads 7-bit value into pc upper latch, flags untouched.
// - literal-to-accumulator loads 8-bit value, flags untouched.
// - accumulator-to-register writes accumulator into addressed file register, no flags.
`default_nettype none
`include "mvd_defs.vh"

module mvd_move_datapath #(
	parameter FAW = 7,
	parameter PW = 16
) (
	input wire mclk_i,
	input wire rst_i,
	input wire ce_i,
	input wire exec_i,
	input wire [13:0] instr_i,
	input wire [7:0] dmem_rdata_i,
	output reg [PW-1:0] dmem_addr_o,
	output reg dmem_rd_o,
	output reg [7:0] acc_o,
	output reg zero_o,
	output reg [4:0] bank_o,
	output reg [6:0] pc_upper_o,
	output reg [PW-1:0] ptr0_o,
	output reg [PW-1:0] ptr1_o,
	output reg busy_o
);

	localparam ST_IDLE = 3'b001;
	localparam ST_FREAD = 3'b010;
	localparam ST_IREAD = 3'b100;

	// sign-extend the 6-bit relative offset to pointer width
	function [PW-1:0] sext_ofs;
		input [5:0] k;
		begin
			sext_ofs = {{(PW-6){k[5]}}, k};
		end
	endfunction

	reg [2:0] state_q, state_d;
	reg [FAW-1:0] faddr_q;
	reg dest_q;
	wire [2:0] op = instr_i[`MVD_OP_HI:`MVD_OP_LO];
	wire [FAW-1:0] faddr = instr_i[`MVD_FADDR_HI:`MVD_FADDR_LO];
	wire [1:0] mode = instr_i[`MVD_MODE_HI:`MVD_MODE_LO];
	wire psel = instr_i[`MVD_PSEL_BIT];
	wire rel = instr_i[`MVD_REL_BIT];
	wire [7:0] lit = instr_i[`MVD_LIT_HI:`MVD_LIT_LO];
	// pointer sums kept at full width, so wrap past either end costs nothing
	wire [PW-1:0] ptr_cur = psel ? ptr1_o : ptr0_o;
	wire [PW-1:0] one = {{(PW-1){1'b0}}, 1'b1};
	wire [PW-1:0] ptr_inc = ptr_cur + one;
	wire [PW-1:0] ptr_dec = ptr_cur - one;
	wire [PW-1:0] ptr_rel = ptr_cur + sext_ofs(instr_i[`MVD_OFS_HI:`MVD_OFS_LO]);
	// a word offered during a read move is dropped; the decoder must watch busy_o
	wire idle = state_q == ST_IDLE;
	wire go = ce_i & exec_i & idle;
	wire [7:0] fr_rdata;
	reg fr_we;
	reg [FAW-1:0] fr_waddr;
	reg [7:0] fr_wdata;
	reg [PW-1:0] eaddr;
	reg [PW-1:0] ptr_next;

	// file register store; read address follows the decoded operand
	// write-back and accumulator store share one write port; go needs idle so they never meet
	mvd_file_ram #(
		.AW(FAW),
		.DW(8)
	) u_fram (
		.mclk_i(mclk_i),
		.ce_i(ce_i),
		.we_i(fr_we),
		.waddr_i(fr_waddr),
		.wdata_i(fr_wdata),
		.raddr_i(faddr),
		.rdata_o(fr_rdata)
	);

	// effective address and pointer update per mode
	// post modes address the old value, pre modes the new one
	always @* begin
		eaddr = ptr_cur;
		ptr_next = ptr_cur;
		if (rel) begin
			eaddr = ptr_rel;
		end else begin
			case (mode)
				`MVD_MODE_PREINC: begin
					eaddr = ptr_inc;
					ptr_next = ptr_inc;
				end
				`MVD_MODE_PREDEC: begin
					eaddr = ptr_dec;
					ptr_next = ptr_dec;
				end
				`MVD_MODE_POSTINC: begin
					eaddr = ptr_cur;
					ptr_next = ptr_inc;
				end
				default: begin
					eaddr = ptr_cur;
					ptr_next = ptr_dec;
				end
			endcase
		end
	end

	// file register write port
	always @* begin
		fr_we = 1'b0;
		fr_waddr = faddr_q;
		fr_wdata = fr_rdata;
		if (state_q == ST_FREAD && dest_q) begin
			fr_we = 1'b1;
		end else if (go && op == `MVD_OP_ACC_REG) begin
			fr_we = 1'b1;
			fr_waddr = faddr;
			fr_wdata = acc_o;
		end
	end

	// sequencing: reads take one extra cycle for memory latency
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (go && op == `MVD_OP_REG_DEST) begin
					state_d = ST_FREAD;
				end else if (go && op == `MVD_OP_IND_LOAD) begin
					state_d = ST_IREAD;
				end
			end
			ST_FREAD: state_d = ST_IDLE;
			ST_IREAD: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// architectural registers
	always @(posedge mclk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			faddr_q <= {FAW{1'b0}};
			dest_q <= 1'b0;
			acc_o <= `MVD_RST_ACC;
			zero_o <= 1'b0;
			bank_o <= `MVD_RST_BANK;
			pc_upper_o <= `MVD_RST_PCU;
			ptr0_o <= `MVD_RST_PTR;
			ptr1_o <= `MVD_RST_PTR;
			dmem_addr_o <= {PW{1'b0}};
			dmem_rd_o <= 1'b0;
			busy_o <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			busy_o <= state_d != ST_IDLE;
			dmem_rd_o <= 1'b0;
			// operands latched, so instr_i may move on during the second cycle
			if (go) begin
				faddr_q <= faddr;
				dest_q <= instr_i[`MVD_DEST_BIT];
				case (op)
					`MVD_OP_IND_LOAD: begin
						dmem_addr_o <= eaddr;
						dmem_rd_o <= 1'b1;
						if (psel) begin
							ptr1_o <= ptr_next;
						end else begin
							ptr0_o <= ptr_next;
						end
					end
					`MVD_OP_LIT_BANK: bank_o <= lit[4:0];
					`MVD_OP_LIT_PCU: pc_upper_o <= lit[6:0];
					`MVD_OP_LIT_ACC: acc_o <= lit;
					default: ;
				endcase
			end
			// ram data registered at the taking edge is valid now
			if (state_q == ST_FREAD) begin
				if (!dest_q) begin
					acc_o <= fr_rdata;
				end
				zero_o <= fr_rdata == 8'h00;
			end
			// external data sampled one cycle after the read strobe
			if (state_q == ST_IREAD) begin
				acc_o <= dmem_rdata_i;
				zero_o <= dmem_rdata_i == 8'h00;
			end
		end
	end

endmodule

`default_nettype wire

// [verif/mvd_chk.sv]
// mvd_chk.sv: port assertions for the move datapath.
// assumes one clock mclk_i and a sync active-high reset rst_i.
`default_nettype none
module mvd_chk #(
	parameter PW = 16
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic exec_i,
	input wire logic [13:0] instr_i,
	input wire logic [7:0] dmem_rdata_i,
	input wire logic [PW-1:0] dmem_addr_o,
	input wire logic dmem_rd_o,
	input wire logic [7:0] acc_o,
	input wire logic zero_o,
	input wire logic [4:0] bank_o,
	input wire logic [6:0] pc_upper_o,
	input wire logic [PW-1:0] ptr0_o,
	input wire logic [PW-1:0] ptr1_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// taken request, chosen pointer, expected address and pointer update
	wire t = ce_i && exec_i && !busy_o;
	wire [2:0] op = instr_i[13:11];
	wire [PW-1:0] p = instr_i[8] ? ptr1_o : ptr0_o;
	wire [PW-1:0] ofs = {{(PW-6){instr_i[5]}}, instr_i[5:0]};
	wire [PW-1:0] ea = instr_i[7] ? p + ofs : instr_i[1] ? p : instr_i[0] ? p - 1'b1 : p + 1'b1;
	wire [PW-1:0] np = instr_i[7] ? p : instr_i[0] ? p - 1'b1 : p + 1'b1;
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	property p_lacc; t && op == 3'h5 |=> acc_o == $past(instr_i[7:0]) && $stable(zero_o); endproperty
	a_lacc: assert property (p_lacc) else $error("literal acc load wrong");
	property p_lbank; t && op == 3'h3 |=> bank_o == $past(instr_i[4:0]); endproperty
	a_lbank: assert property (p_lbank) else $error("bank load wrong");
	property p_lpcu; t && op == 3'h4 |=> pc_upper_o == $past(instr_i[6:0]); endproperty
	a_lpcu: assert property (p_lpcu) else $error("pc upper load wrong");
	property p_ea; t && op == 3'h2 |=> dmem_addr_o == $past(ea) && dmem_rd_o; endproperty
	a_ea: assert property (p_ea) else $error("indirect address wrong");
	property p_ptr; t && op == 3'h2 |=> ($past(instr_i[8]) ? ptr1_o : ptr0_o) == $past(np); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer update wrong");
	property p_rd;
		dmem_rd_o && ce_i |=> acc_o == $past(dmem_rdata_i) && zero_o == ($past(dmem_rdata_i) == 8'h00);
	endproperty
	a_rd: assert property (p_rd) else $error("indirect data not loaded");
	property p_busy; t && (op == 3'h1 || op == 3'h2) |=> busy_o ##1 (busy_o == !$past(ce_i)); endproperty
	a_busy: assert property (p_busy) else $error("read move timing wrong");
	property p_keepz; t && op >= 3'h3 && op <= 3'h6 |=> $stable(zero_o); endproperty
	a_keepz: assert property (p_keepz) else $error("zero flag disturbed");
endmodule
bind mvd_move_datapath mvd_chk #(
	.PW(PW)
) u_chk (
	.mclk_i(mclk_i),
	.rst_i(rst_i),
	.ce_i(ce_i),
	.exec_i(exec_i),
	.instr_i(instr_i),
	.dmem_rdata_i(dmem_rdata_i),
	.dmem_addr_o(dmem_addr_o),
	.dmem_rd_o(dmem_rd_o),
	.acc_o(acc_o),
	.zero_o(zero_o),
	.bank_o(bank_o),
	.pc_upper_o(pc_upper_o),
	.ptr0_o(ptr0_o),
	.ptr1_o(ptr1_o),
	.busy_o(busy_o)
);
`default_nettype wire

// [verif/tb_top.sv]
// tb_top.sv: directed bench for the move datapath.
// assumes the bench plays decoder and data memory; ce_i held high except one freeze.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, exec_i = 1'b0;
	logic [13:0] instr_i = 14'h0000;
	logic [7:0] dmem_rdata_i = 8'h00;
	wire [15:0] dmem_addr_o, ptr0_o, ptr1_o;
	wire [7:0] acc_o;
	wire [4:0] bank_o;
	wire [6:0] pc_upper_o;
	wire dmem_rd_o, zero_o, busy_o;
	int fails = 0, check_count = 0;
	mvd_move_datapath u_mvd_move_datapath (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.exec_i(exec_i),
		.instr_i(instr_i),
		.dmem_rdata_i(dmem_rdata_i),
		.dmem_addr_o(dmem_addr_o),
		.dmem_rd_o(dmem_rd_o),
		.acc_o(acc_o),
		.zero_o(zero_o),
		.bank_o(bank_o),
		.pc_upper_o(pc_upper_o),
		.ptr0_o(ptr0_o),
		.ptr1_o(ptr1_o),
		.busy_o(busy_o)
	);
	initial forever #5 mclk_i = ~mclk_i;
	task chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("FAIL at %0t seen %h exp %h", $time, s, e);
		end
	endtask
	// issue one word; returns just after the taking edge, exec left high
	task ex(input logic [13:0] w);
		exec_i = 1'b1;
		instr_i = w;
		@(posedge mclk_i);
		#1;
	endtask
	task idle;
		exec_i = 1'b0;
		@(posedge mclk_i);
		#1;
	endtask
	// exec stays high while busy, so a repeat must be refused
	task ind(input logic [13:0] w, input logic [15:0] ea, p, input logic [7:0] d);
		ex(w);
		chk(dmem_addr_o, ea);
		chk(w[8] ? ptr1_o : ptr0_o, p);
		chk(dmem_rd_o, 16'h0001);
		chk(busy_o, 16'h0001);
		dmem_rdata_i = d;
		@(posedge mclk_i);
		#1;
		chk(acc_o, d);
		chk(zero_o, d == 8'h00);
		chk(w[8] ? ptr1_o : ptr0_o, p);
		chk(dmem_rd_o, 16'h0000);
		chk(busy_o, 16'h0000);
		dmem_rdata_i = ~d;
		idle;
	endtask
	task t_lit;
		ex({3'h5, 3'h0, 8'h5a});
		chk(acc_o, 16'h005a);
		ex({3'h3, 6'h00, 5'h1f});
		chk(bank_o, 16'h001f);
		ex({3'h4, 4'h0, 7'h7f});
		chk(pc_upper_o, 16'h007f);
		ex({3'h5, 3'h0, 8'h00});
		chk(zero_o, 16'h0000);
		ce_i = 1'b0;
		ex({3'h5, 3'h0, 8'h11});
		ce_i = 1'b1;
		chk(acc_o, 16'h0000);
		ex({3'h7, 11'h0ff});
		chk(acc_o, 16'h0000);
		chk(bank_o, 16'h001f);
		idle;
		$display("literal moves done");
	endtask
	task t_reg;
		ex({3'h5, 3'h0, 8'h00});
		ex({3'h6, 4'h0, 7'h7f});
		ex({3'h5, 3'h0, 8'h33});
		ex({3'h1, 3'h0, 1'b0, 7'h7f});
		idle;
		chk(acc_o, 16'h0000);
		chk(zero_o, 16'h0001);
		ex({3'h5, 3'h0, 8'hc3});
		ex({3'h6, 4'h0, 7'h7f});
		ex({3'h5, 3'h0, 8'h00});
		ex({3'h1, 3'h0, 1'b1, 7'h7f});
		idle;
		chk(acc_o, 16'h0000);
		chk(zero_o, 16'h0000);
		ex({3'h1, 3'h0, 1'b0, 7'h7f});
		idle;
		chk(acc_o, 16'h00c3);
		$display("register moves done");
	endtask
	task t_ind;
		ind({5'h08, 9'h001}, 16'hffff, 16'hffff, 8'h00);
		ind({5'h08, 9'h000}, 16'h0000, 16'h0000, 8'ha5);
		ind({5'h08, 9'h102}, 16'h0000, 16'h0001, 8'h01);
		ind({5'h08, 9'h103}, 16'h0001, 16'h0000, 8'h80);
		ind({5'h08, 9'h0a0}, 16'hffe0, 16'h0000, 8'h00);
		ind({5'h08, 9'h19f}, 16'h001f, 16'h0000, 8'h7e);
		ind({5'h08, 9'h103}, 16'h0000, 16'hffff, 8'h5c);
		$display("indirect loads done");
	endtask
	// mid-run reset clears bank, pc upper latch, accumulator, ptr1 and zero (checked here); a word right after release is taken
	task t_rst;
		ex({3'h3, 6'h00, 5'h15});
		rst_i = 1'b1;
		idle;
		rst_i = 1'b0;
		chk(bank_o, 16'h0000);
		chk(pc_upper_o, 16'h0000);
		chk(acc_o, 16'h0000);
		chk(ptr1_o, 16'h0000);
		chk(zero_o, 16'h0000);
		ex({3'h5, 3'h0, 8'h3c});
		chk(acc_o, 16'h003c);
		idle;
		$display("mid-run reset done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk_i);
		#1;
		rst_i = 1'b0;
		chk(acc_o, 16'h0000);
		t_lit;
		t_reg;
		t_ind;
		t_rst;
		stop_test;
	end
	// hang guard, far beyond the 46 cycles the tests need
	initial begin
		#20000;
		fails++;
		stop_test;
	end
endmodule
`default_nettype wire
